// >>> gos_map.vh
// register indices, field positions and reset values of the rate offset and self-test bank
`ifndef GOS_MAP_VH
`define GOS_MAP_VH

// register indices; the wishbone byte address is four times the index
`define GOS_IDX_ST_X 8'h00
`define GOS_IDX_ST_Y 8'h01
`define GOS_IDX_ST_Z 8'h02
`define GOS_IDX_OFS_XH 8'h13
`define GOS_IDX_OFS_XL 8'h14
`define GOS_IDX_OFS_YH 8'h15
`define GOS_IDX_OFS_YL 8'h16
`define GOS_IDX_OFS_ZH 8'h17
`define GOS_IDX_OFS_ZL 8'h18
`define GOS_IDX_RATE_XH 8'h43
`define GOS_IDX_RATE_XL 8'h44
`define GOS_IDX_RATE_YH 8'h45
`define GOS_IDX_RATE_YL 8'h46
`define GOS_IDX_RATE_ZH 8'h47
`define GOS_IDX_RATE_ZL 8'h48
`define GOS_IDX_PWR1 8'h6B
`define GOS_IDX_IDENT 8'h75

// address layout of the wishbone slave
`define GOS_ADR_W 10
`define GOS_IDX_LSB 2
`define GOS_IDX_MSB 9

// reset values
`define GOS_RST_ZERO 8'h00
`define GOS_RST_PWR1 8'h40
`define GOS_RST_RATE 16'h0000

// power management 1 fields
`define GOS_PWR1_SLEEP_BIT 6

// saturation limits of the 16-bit output
`define GOS_SAT_MAX 16'h7FFF
`define GOS_SAT_MIN 16'h8000

`endif

// >>> gos_offset_add.v
// one axis: adds the signed bias trim to a raw sample and holds the saturated result
`default_nettype none

module gos_offset_add #(
    parameter W = 16
) (
    // clock, reset, enable
    input wire clk_i,
    input wire rst_i,
    input wire ce_i,
    // sample path
    input wire load_i,
    input wire [W-1:0] raw_i,
    input wire [W-1:0] trim_i,
    output reg [W-1:0] rate_o
);

    wire [W:0] sum_ext;
    wire ovf_pos;
    wire ovf_neg;
    reg [W-1:0] nxt_rate;

    // sign-extended add keeps the carry so that overflow can be seen
    assign sum_ext = {raw_i[W-1], raw_i} + {trim_i[W-1], trim_i};
    assign ovf_pos = (sum_ext[W] == 1'b0) && (sum_ext[W-1] == 1'b1);
    assign ovf_neg = (sum_ext[W] == 1'b1) && (sum_ext[W-1] == 1'b0);

    always @*
    begin
        nxt_rate = rate_o;
        if (load_i)
        begin
            if (ovf_pos)
                nxt_rate = {1'b0, {(W-1){1'b1}}};
            else if (ovf_neg)
                nxt_rate = {1'b1, {(W-1){1'b0}}};
            else
                nxt_rate = sum_ext[W-1:0];
        end
    end

    always @(posedge clk_i)
    begin
        if (rst_i)
            rate_o <= {W{1'b0}};
        else if (ce_i)
            rate_o <= nxt_rate;
    end

endmodule

`default_nettype wire

// >>> gos_regs.v
// register bank of a three-axis rate sensor: bias trims, factory test codes, power, outputs
// Function
// - every other register resets to zero
// - power management one resets to 0x40
// - factory test codes survive reset unchanged; here reset reloads FACTORY_CODE_X/Y/Z and a written code is lost
// - device sleeps after power-up until software wakes
// - high register bits 15:8, low bits 7:0
// - trim added to raw sample before output
// - trim registers at 0x13 to 0x18, read/write
// - test codes x, y, z at 0x00-0x02
//
// Implementation choice: register access over Wishbone.
`default_nettype none
`include "gos_map.vh"

// register map by index; the bus byte address is four times the index
//   0x00 to 0x02: factory test codes x, y, z, writable, reloaded by reset
//   0x13 to 0x18: bias trims, high byte then low byte for x, y and z
//   0x43 to 0x48: corrected rate outputs, read only, each byte read live
//   0x6B: power control one, only bit 6 (sleep) acts, the rest is stored
//   0x75: identity, read only
//   any other index reads zero, ignores writes and is still acked
// the bus answers one cycle after a request and the answer stands one cycle;
// a write lands on the edge where the master sees ack, so it must hold until then

module gos_regs #(
    parameter [7:0] FACTORY_CODE_X = 8'h01,
    parameter [7:0] FACTORY_CODE_Y = 8'h01,
    parameter [7:0] FACTORY_CODE_Z = 8'h01,
    // identity value is arbitrary
    parameter [7:0] IDENTITY_CODE = 8'h5A,
    parameter W = 16
) (
    // clock, reset, enable
    input wire clk_i,
    input wire rst_i,
    input wire ce_i,
    // wishbone classic slave
    input wire cyc_i,
    input wire stb_i,
    input wire we_i,
    input wire [`GOS_ADR_W-1:0] adr_i,
    input wire [3:0] sel_i,
    input wire [31:0] dat_i,
    output reg [31:0] dat_o,
    output reg ack_o,
    // raw rate samples
    input wire sample_valid_i,
    input wire [W-1:0] raw_x_i,
    input wire [W-1:0] raw_y_i,
    input wire [W-1:0] raw_z_i,
    // corrected rate outputs and power state
    output wire [W-1:0] x_rate_output_o,
    output wire [W-1:0] y_rate_output_o,
    output wire [W-1:0] z_rate_output_o,
    output wire sleep_o
);

    ////////////////////////////////////////////////////////////////////////////////
    // storage

    reg [7:0] selftest_code_x_ff;
    reg [7:0] selftest_code_y_ff;
    reg [7:0] selftest_code_z_ff;
    reg [7:0] offset_x_high_ff;
    reg [7:0] offset_x_low_ff;
    reg [7:0] offset_y_high_ff;
    reg [7:0] offset_y_low_ff;
    reg [7:0] offset_z_high_ff;
    reg [7:0] offset_z_low_ff;
    reg [7:0] pwr_mgmt1_ff;
    reg ack_ff;
    reg [31:0] rdat_ff;

    // next values, settled by the combinational blocks below
    reg [7:0] nxt_selftest_code_x;
    reg [7:0] nxt_selftest_code_y;
    reg [7:0] nxt_selftest_code_z;
    reg [7:0] nxt_offset_x_high;
    reg [7:0] nxt_offset_x_low;
    reg [7:0] nxt_offset_y_high;
    reg [7:0] nxt_offset_y_low;
    reg [7:0] nxt_offset_z_high;
    reg [7:0] nxt_offset_z_low;
    reg [7:0] nxt_pwr_mgmt1;
    reg nxt_ack;
    reg [31:0] nxt_rdat;
    reg [7:0] rd_byte;

    wire [7:0] reg_idx;
    wire req;
    wire wr_commit;
    wire [7:0] wbyte;
    wire [W-1:0] x_bias_trim;
    wire [W-1:0] y_bias_trim;
    wire [W-1:0] z_bias_trim;
    wire sample_load;
    wire wr_en;
    // one write strobe per writable register
    wire wr_st_x;
    wire wr_st_y;
    wire wr_st_z;
    wire wr_ofs_xh;
    wire wr_ofs_xl;
    wire wr_ofs_yh;
    wire wr_ofs_yl;
    wire wr_ofs_zh;
    wire wr_ofs_zl;
    wire wr_pwr1;

    ////////////////////////////////////////////////////////////////////////////////
    // bus decode

    assign reg_idx = adr_i[`GOS_IDX_MSB:`GOS_IDX_LSB];
    assign req = cyc_i && stb_i;
    // a write lands on the edge where the master sees ack high
    // a write with sel_i[0] low is acked but changes nothing
    assign wr_en = req && we_i && sel_i[0];
    assign wr_commit = wr_en && ack_ff;
    assign wbyte = dat_i[7:0];

    // strobes fire only on the edge where the master sees ack
    assign wr_st_x = wr_commit && (reg_idx == `GOS_IDX_ST_X);
    assign wr_st_y = wr_commit && (reg_idx == `GOS_IDX_ST_Y);
    assign wr_st_z = wr_commit && (reg_idx == `GOS_IDX_ST_Z);
    assign wr_ofs_xh = wr_commit && (reg_idx == `GOS_IDX_OFS_XH);
    assign wr_ofs_xl = wr_commit && (reg_idx == `GOS_IDX_OFS_XL);
    assign wr_ofs_yh = wr_commit && (reg_idx == `GOS_IDX_OFS_YH);
    assign wr_ofs_yl = wr_commit && (reg_idx == `GOS_IDX_OFS_YL);
    assign wr_ofs_zh = wr_commit && (reg_idx == `GOS_IDX_OFS_ZH);
    assign wr_ofs_zl = wr_commit && (reg_idx == `GOS_IDX_OFS_ZL);
    assign wr_pwr1 = wr_commit && (reg_idx == `GOS_IDX_PWR1);

    // ack rises one cycle after the request and drops the cycle after it was given
    always @*
    begin
        nxt_ack = 1'b0;
        if (req && !ack_ff)
            nxt_ack = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // read path

    always @*
    begin
        rd_byte = 8'h00;
        case (reg_idx)
            // factory test codes
            `GOS_IDX_ST_X: rd_byte = selftest_code_x_ff;
            `GOS_IDX_ST_Y: rd_byte = selftest_code_y_ff;
            `GOS_IDX_ST_Z: rd_byte = selftest_code_z_ff;
            // bias trims
            `GOS_IDX_OFS_XH: rd_byte = offset_x_high_ff;
            `GOS_IDX_OFS_XL: rd_byte = offset_x_low_ff;
            `GOS_IDX_OFS_YH: rd_byte = offset_y_high_ff;
            `GOS_IDX_OFS_YL: rd_byte = offset_y_low_ff;
            `GOS_IDX_OFS_ZH: rd_byte = offset_z_high_ff;
            `GOS_IDX_OFS_ZL: rd_byte = offset_z_low_ff;
            // corrected outputs, read only
            `GOS_IDX_RATE_XH: rd_byte = x_rate_output_o[15:8];
            `GOS_IDX_RATE_XL: rd_byte = x_rate_output_o[7:0];
            `GOS_IDX_RATE_YH: rd_byte = y_rate_output_o[15:8];
            `GOS_IDX_RATE_YL: rd_byte = y_rate_output_o[7:0];
            `GOS_IDX_RATE_ZH: rd_byte = z_rate_output_o[15:8];
            `GOS_IDX_RATE_ZL: rd_byte = z_rate_output_o[7:0];
            // power and identity
            `GOS_IDX_PWR1: rd_byte = pwr_mgmt1_ff;
            `GOS_IDX_IDENT: rd_byte = IDENTITY_CODE;
            default: rd_byte = 8'h00;
        endcase
    end

    // read data is captured together with ack and stands only while ack is high
    always @*
    begin
        nxt_rdat = 32'h00000000;
        if (req && !ack_ff)
            nxt_rdat = {24'h000000, rd_byte};
    end

    ////////////////////////////////////////////////////////////////////////////////
    // write path

    always @*
    begin
        nxt_selftest_code_x = selftest_code_x_ff;
        nxt_selftest_code_y = selftest_code_y_ff;
        nxt_selftest_code_z = selftest_code_z_ff;
        nxt_offset_x_high = offset_x_high_ff;
        nxt_offset_x_low = offset_x_low_ff;
        nxt_offset_y_high = offset_y_high_ff;
        nxt_offset_y_low = offset_y_low_ff;
        nxt_offset_z_high = offset_z_high_ff;
        nxt_offset_z_low = offset_z_low_ff;
        nxt_pwr_mgmt1 = pwr_mgmt1_ff;
        // factory test codes
        if (wr_st_x)
            nxt_selftest_code_x = wbyte;
        if (wr_st_y)
            nxt_selftest_code_y = wbyte;
        if (wr_st_z)
            nxt_selftest_code_z = wbyte;
        // bias trims
        if (wr_ofs_xh)
            nxt_offset_x_high = wbyte;
        if (wr_ofs_xl)
            nxt_offset_x_low = wbyte;
        if (wr_ofs_yh)
            nxt_offset_y_high = wbyte;
        if (wr_ofs_yl)
            nxt_offset_y_low = wbyte;
        if (wr_ofs_zh)
            nxt_offset_z_high = wbyte;
        if (wr_ofs_zl)
            nxt_offset_z_low = wbyte;
        // power control; only the sleep bit acts
        if (wr_pwr1)
            nxt_pwr_mgmt1 = wbyte;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // registers

    // bus response advances only with the enable
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_ff <= 1'b0;
            rdat_ff <= 32'h00000000;
        end
        else if (ce_i)
        begin
            ack_ff <= nxt_ack;
            rdat_ff <= nxt_rdat;
        end
    end

    // factory codes reload their programmed values rather than clearing
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            selftest_code_x_ff <= FACTORY_CODE_X;
            selftest_code_y_ff <= FACTORY_CODE_Y;
            selftest_code_z_ff <= FACTORY_CODE_Z;
        end
        else if (ce_i)
        begin
            selftest_code_x_ff <= nxt_selftest_code_x;
            selftest_code_y_ff <= nxt_selftest_code_y;
            selftest_code_z_ff <= nxt_selftest_code_z;
        end
    end

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            offset_x_high_ff <= `GOS_RST_ZERO;
            offset_x_low_ff <= `GOS_RST_ZERO;
            offset_y_high_ff <= `GOS_RST_ZERO;
            offset_y_low_ff <= `GOS_RST_ZERO;
            offset_z_high_ff <= `GOS_RST_ZERO;
            offset_z_low_ff <= `GOS_RST_ZERO;
        end
        else if (ce_i)
        begin
            offset_x_high_ff <= nxt_offset_x_high;
            offset_x_low_ff <= nxt_offset_x_low;
            offset_y_high_ff <= nxt_offset_y_high;
            offset_y_low_ff <= nxt_offset_y_low;
            offset_z_high_ff <= nxt_offset_z_high;
            offset_z_low_ff <= nxt_offset_z_low;
        end
    end

    // power-up leaves the sleep bit set
    always @(posedge clk_i)
    begin
        if (rst_i)
            pwr_mgmt1_ff <= `GOS_RST_PWR1;
        else if (ce_i)
            pwr_mgmt1_ff <= nxt_pwr_mgmt1;
    end

    always @*
    begin
        dat_o = rdat_ff;
        ack_o = ack_ff;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // sample path

    assign sleep_o = pwr_mgmt1_ff[`GOS_PWR1_SLEEP_BIT];
    // asleep, the outputs keep their last value
    assign sample_load = sample_valid_i && !sleep_o;

    // the pair forms one 16-bit trim, used as it stands at each sample
    assign x_bias_trim = {offset_x_high_ff, offset_x_low_ff};
    assign y_bias_trim = {offset_y_high_ff, offset_y_low_ff};
    assign z_bias_trim = {offset_z_high_ff, offset_z_low_ff};

    gos_offset_add #(
        .W(W)
    ) u_add_x (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .load_i(sample_load),
        .raw_i(raw_x_i),
        .trim_i(x_bias_trim),
        .rate_o(x_rate_output_o)
    );

    gos_offset_add #(
        .W(W)
    ) u_add_y (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .load_i(sample_load),
        .raw_i(raw_y_i),
        .trim_i(y_bias_trim),
        .rate_o(y_rate_output_o)
    );

    gos_offset_add #(
        .W(W)
    ) u_add_z (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .load_i(sample_load),
        .raw_i(raw_z_i),
        .trim_i(z_bias_trim),
        .rate_o(z_rate_output_o)
    );

endmodule

`default_nettype wire

// >>> gos_regs_properties.sv
// port-level checker of the rate offset and factory test bank
`default_nettype none
`include "gos_map.vh"

module gos_regs_properties #(
    parameter W = 16
) (
    // clock, reset, enable
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // wishbone classic slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [`GOS_ADR_W-1:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    // raw samples
    input wire logic sample_valid_i,
    input wire logic [W-1:0] raw_x_i,
    input wire logic [W-1:0] raw_y_i,
    input wire logic [W-1:0] raw_z_i,
    // outputs
    input wire logic [W-1:0] x_rate_output_o,
    input wire logic [W-1:0] y_rate_output_o,
    input wire logic [W-1:0] z_rate_output_o,
    input wire logic sleep_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_i);
    endclocking

    ////////////////////////////////////////////////////////////////////////////////
    property p_ack_once;
        disable iff (rst_i) ack_o |=> !ack_o;
    endproperty
    a_ack_once: assert property (p_ack_once) else $error("ack longer than one cycle");
    property p_ack_next;
        disable iff (rst_i) (cyc_i && stb_i && !ack_o && ce_i) |=> ack_o;
    endproperty
    a_ack_next: assert property (p_ack_next) else $error("request not acked next cycle");
    property p_dat_idle;
        disable iff (rst_i) !ack_o |-> dat_o == 32'h0;
    endproperty
    a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");
    property p_dat_high;
        disable iff (rst_i) dat_o[31:8] == 24'h0;
    endproperty
    a_dat_high: assert property (p_dat_high) else $error("upper read bits not zero");
    property p_rst_sleep;
        (rst_i && ce_i) |=> sleep_o;
    endproperty
    a_rst_sleep: assert property (p_rst_sleep) else $error("not asleep after reset");
    property p_rst_zero;
        (rst_i && ce_i) |=> !ack_o && x_rate_output_o == 16'h0 && z_rate_output_o == 16'h0;
    endproperty
    a_rst_zero: assert property (p_rst_zero) else $error("outputs not cleared");
    property p_hold;
        disable iff (rst_i) !(sample_valid_i && !sleep_o) |=> $stable(x_rate_output_o)
            && $stable(y_rate_output_o) && $stable(z_rate_output_o);
    endproperty
    a_hold: assert property (p_hold) else $error("rate output moved without sample");
    property p_wake;
        disable iff (rst_i) (ack_o && cyc_i && stb_i && we_i && sel_i[0]
            && adr_i[9:2] == `GOS_IDX_PWR1) |=> ##1 sleep_o == $past(dat_i[6], 2);
    endproperty
    a_wake: assert property (p_wake) else $error("sleep bit not taken from write");
    c_wake: cover property (ack_o && we_i && adr_i[9:2] == `GOS_IDX_PWR1);
    c_sample: cover property (sample_valid_i && !sleep_o);
    c_read: cover property (ack_o && !we_i);
endmodule

bind gos_regs gos_regs_properties #(.W(W)) chk_u (.*);
`default_nettype wire

// >>> gos_sensor_model.sv
// sensor front end model: one-cycle raw sample strobes
`default_nettype none

module gos_sensor_model (
    // clock
    input wire logic clk_i,
    // sample path
    output logic sample_valid_o,
    output logic [15:0] raw_x_o,
    output logic [15:0] raw_y_o,
    output logic [15:0] raw_z_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        sample_valid_o = 1'b0;
        {raw_x_o, raw_y_o, raw_z_o} = 48'h0;
    end
    // after each strobe the lines carry the inverse, never the stale sample
    task send(input logic [15:0] x, input logic [15:0] y, input logic [15:0] z);
        @(posedge clk_i);
        sample_valid_o <= 1'b1;
        {raw_x_o, raw_y_o, raw_z_o} <= {x, y, z};
        @(posedge clk_i);
        sample_valid_o <= 1'b0;
        {raw_x_o, raw_y_o, raw_z_o} <= ~{x, y, z};
    endtask
endmodule
`default_nettype wire

// >>> tb.sv
// self-checking bench of the rate offset and factory test bank
`default_nettype none
`include "gos_map.vh"
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_errors++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end

module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam [7:0] CODE_X = 8'h3C;
    localparam [7:0] CODE_Y = 8'hA7;
    localparam [7:0] CODE_Z = 8'h51;
    // identity value is arbitrary
    localparam [7:0] IDENT = 8'h2D;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic ce_i = 1'b1;
    logic cyc_i = 1'b0;
    logic stb_i = 1'b0;
    logic we_i = 1'b0;
    logic [`GOS_ADR_W-1:0] adr_i = '0;
    logic [3:0] sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0;
    logic [31:0] dat_o;
    logic ack_o, sample_valid_i, sleep_o;
    logic [15:0] raw_x_i, raw_y_i, raw_z_i, x_o, y_o, z_o;
    logic [7:0] rd;
    int n_errors = 0;
    int checked = 0;

    always #10 clk_i = ~clk_i;
    gos_regs #(.FACTORY_CODE_X(CODE_X), .FACTORY_CODE_Y(CODE_Y), .FACTORY_CODE_Z(CODE_Z),
        .IDENTITY_CODE(IDENT), .W(16)) dut_u (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
        .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
        .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .sample_valid_i(sample_valid_i),
        .raw_x_i(raw_x_i), .raw_y_i(raw_y_i), .raw_z_i(raw_z_i), .x_rate_output_o(x_o),
        .y_rate_output_o(y_o), .z_rate_output_o(z_o), .sleep_o(sleep_o));
    gos_sensor_model sensor_u (.clk_i(clk_i), .sample_valid_o(sample_valid_i),
        .raw_x_o(raw_x_i), .raw_y_o(raw_y_i), .raw_z_o(raw_z_i));

    ////////////////////////////////////////////////////////////////////////////////
    task wb(input logic w, input logic [7:0] idx, input logic [7:0] d, input logic s0);
        int n;
        @(posedge clk_i);
        {cyc_i, stb_i, we_i} <= {2'b11, w};
        adr_i <= {idx, 2'b00};
        sel_i <= {3'b000, s0};
        dat_i <= {24'h0, d};
        n = 0;
        // ack and read data are taken at the rising edge that samples ack high
        do @(posedge clk_i); while (ack_o !== 1'b1 && ++n < 20);
        if (ack_o !== 1'b1)
            n_errors++;
        rd = dat_o[7:0];
        {cyc_i, stb_i} <= 2'b00;
    endtask
    task rd_chk(input logic [7:0] idx, input logic [7:0] e);
        wb(1'b0, idx, 8'h00, 1'b1);
        `CHK(rd, e)
    endtask
    task set_trim(input int a, input logic [15:0] v);
        wb(1'b1, 8'h13 + 2 * a, v[15:8], 1'b1);
        wb(1'b1, 8'h14 + 2 * a, v[7:0], 1'b1);
    endtask
    function logic [15:0] sat(input logic [15:0] a, input logic [15:0] b);
        logic signed [16:0] s;
        s = $signed({a[15], a}) + $signed({b[15], b});
        if (s > 17'sd32767)
            return 16'h7FFF;
        if (s < -17'sd32768)
            return 16'h8000;
        return s[15:0];
    endfunction
    task sample_chk(input logic [15:0] x, y, z, tx, ty, tz);
        logic [15:0] e;
        sensor_u.send(x, y, z);
        @(negedge clk_i);
        `CHK(y_o, sat(y, ty))
        `CHK(z_o, sat(z, tz))
        e = sat(x, tx);
        `CHK(x_o, e)
        rd_chk(`GOS_IDX_RATE_XH, e[15:8]);
        rd_chk(`GOS_IDX_RATE_XL, e[7:0]);
    endtask
    task t_reset_vals;
        rd_chk(`GOS_IDX_ST_X, CODE_X);
        rd_chk(`GOS_IDX_ST_Y, CODE_Y);
        rd_chk(`GOS_IDX_ST_Z, CODE_Z);
        for (int i = 8'h13; i <= 8'h18; i++)
            rd_chk(i[7:0], 8'h00);
        rd_chk(`GOS_IDX_PWR1, 8'h40);
        rd_chk(`GOS_IDX_IDENT, IDENT);
        rd_chk(8'h30, 8'h00);
        `CHK(sleep_o, 1'b1)
    endtask
    task t_sleep;
        sensor_u.send(16'h1234, 16'h1234, 16'h1234);
        @(negedge clk_i);
        `CHK(x_o, 16'h0000)
        wb(1'b1, `GOS_IDX_PWR1, 8'h00, 1'b1);
        repeat (2) @(negedge clk_i);
        `CHK(sleep_o, 1'b0)
    endtask
    task t_trim;
        for (int a = 0; a < 3; a++)
        begin
            set_trim(a, {8'hA5 ^ a[7:0], 8'h3C + a[7:0]});
            wb(1'b1, 8'h13 + 2 * a, 8'hFF, 1'b0);
            rd_chk(8'h13 + 2 * a, 8'hA5 ^ a[7:0]);
            rd_chk(8'h14 + 2 * a, 8'h3C + a[7:0]);
        end
    endtask
    task t_add;
        set_trim(0, 16'h0100);
        set_trim(1, 16'hFFF0);
        set_trim(2, 16'h0001);
        sample_chk(16'h1000, 16'h0005, 16'h7FFF, 16'h0100, 16'hFFF0, 16'h0001);
        wb(1'b1, `GOS_IDX_OFS_XL, 8'h80, 1'b1);
        sample_chk(16'h8000, 16'h8000, 16'h8000, 16'h0180, 16'hFFF0, 16'h0001);
    endtask
    task t_reset_mid;
        wb(1'b1, `GOS_IDX_ST_X, 8'h99, 1'b1);
        rd_chk(`GOS_IDX_ST_X, 8'h99);
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rd_chk(`GOS_IDX_ST_X, CODE_X);
        rd_chk(`GOS_IDX_OFS_XH, 8'h00);
        rd_chk(`GOS_IDX_ST_Z, CODE_Z);
        `CHK(sleep_o, 1'b1)
        `CHK(x_o, 16'h0000)
    endtask
    // with the enable low a sample is ignored; once it returns samples load again
    task t_freeze;
        @(posedge clk_i);
        ce_i <= 1'b0;
        sensor_u.send(16'h0042, 16'h0042, 16'h0042);
        @(negedge clk_i);
        `CHK(x_o, sat(16'h8000, 16'h0180))
        @(posedge clk_i);
        ce_i <= 1'b1;
        sample_chk(16'h0042, 16'h0042, 16'h0042, 16'h0180, 16'hFFF0, 16'h0001);
    endtask
    task summarize;
        if (n_errors == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    initial
    begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset_vals();
        t_sleep();
        t_trim();
        t_add();
        t_freeze();
        t_reset_mid();
        summarize();
    end
    initial
    begin
        #1000000;
        n_errors++;
        summarize();
    end
endmodule
`default_nettype wire
